// ### rtl/eecmd_cfg.svh
// offsets, field positions and timing counts of the eeprom command unit
// assumes 32-bit register port with byte addresses and a 125 MHz core clock
`ifndef EECMD_CFG_SVH
`define EECMD_CFG_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define EECMD_OFS_CMD 8'hb0
`define EECMD_OFS_DATA 8'hb4
`define EECMD_OFS_ISTS 8'hb8
`define EECMD_OFS_ICLR 8'hbc
`define EECMD_OFS_IEN 8'hc0

// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define EECMD_BUSY_BIT 31
`define EECMD_OP_LSB 28
`define EECMD_TMO_BIT 9
`define EECMD_OP_READ 3'h0
`define EECMD_OP_WRITE 3'h3
`define EECMD_IRQ_DONE 0
`define EECMD_IRQ_TMO 1
`define EECMD_MAC_BYTES 6

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define EECMD_CLK_MHZ 125
`define EECMD_TIMEOUT_US 1000
`define EECMD_TIMEOUT_CYC (`EECMD_TIMEOUT_US * `EECMD_CLK_MHZ)
`define EECMD_SCK_NS 800
`define EECMD_SCK_DIV ((`EECMD_SCK_NS / 2) / (1000 / `EECMD_CLK_MHZ))

`endif

// ### rtl/eecmd_engine.sv
// serial engine: shifts a command frame to the eeprom and, for a read, a byte back
// assumes start only while idle; miso comes from a pin and is synchronised here
`timescale 1ns/10ps
`include "eecmd_cfg.svh"
module eecmd_engine
    import eecmd_pkg::*;
#(
    parameter int TIMEOUT_CYC = `EECMD_TIMEOUT_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    eecmd_if.eng eng,
    output logic ee_cs,
    output logic ee_sck,
    output logic ee_mosi,
    input wire logic ee_miso
);
    initial begin
        if (TIMEOUT_CYC < 2) $error("timeout too short");
    end

    eecmd_eng_type st_ff, nxt_st;
    logic [18:0] sh_ff, nxt_sh;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [7:0] rd_ff, nxt_rd;
    logic [7:0] div_ff, nxt_div;
    logic [31:0] to_ff, nxt_to;
    logic ph_ff, nxt_ph, cs_ff, nxt_cs, sck_ff, nxt_sck, tmo_ff, nxt_tmo, wr_ff, nxt_wr;
    logic miso_m_ff, miso_s_ff;
    logic tick;

    assign tick = (div_ff == 8'(`EECMD_SCK_DIV - 1));
    assign eng.done = (st_ff == EECMD_E_DONE);
    assign eng.rdata = rd_ff;
    assign eng.tmo = tmo_ff;
    assign ee_cs = cs_ff;
    assign ee_sck = sck_ff;
    assign ee_mosi = sh_ff[18];

    always_comb begin
        nxt_st = st_ff;
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        nxt_rd = rd_ff;
        nxt_to = to_ff;
        nxt_ph = ph_ff;
        nxt_cs = cs_ff;
        nxt_sck = sck_ff;
        nxt_tmo = tmo_ff;
        nxt_wr = wr_ff;
        nxt_div = tick ? 8'h00 : div_ff + 8'h01;
        unique case (st_ff)
            EECMD_E_IDLE: begin
                if (eng.start) begin
                    nxt_st = EECMD_E_SEND;
                    nxt_wr = eng.is_write;
                    nxt_sh = {1'b1, eng.is_write, ~eng.is_write, eng.addr, eng.wdata};
                    nxt_cnt = eng.is_write ? 5'h13 : 5'h0b;
                    nxt_cs = 1'b1;
                    nxt_ph = 1'b0;
                    nxt_tmo = 1'b0;
                    nxt_to = 32'h0;
                    nxt_div = 8'h00;
                end
            end
            EECMD_E_SEND: begin
                if (tick) begin
                    nxt_ph = ~ph_ff;
                    nxt_sck = ~ph_ff;
                    if (ph_ff) begin
                        nxt_sh = {sh_ff[17:0], 1'b0};
                        nxt_cnt = cnt_ff - 5'h01;
                        if (cnt_ff == 5'h01) begin
                            nxt_st = wr_ff ? EECMD_E_WAIT : EECMD_E_RECV;
                            nxt_cnt = 5'h08;
                            nxt_cs = ~wr_ff;
                        end
                    end
                end
            end
            EECMD_E_RECV: begin
                if (tick) begin
                    nxt_ph = ~ph_ff;
                    nxt_sck = ~ph_ff;
                    if (!ph_ff) begin
                        nxt_rd = {rd_ff[6:0], miso_s_ff};
                    end else begin
                        nxt_cnt = cnt_ff - 5'h01;
                        if (cnt_ff == 5'h01) begin
                            nxt_st = EECMD_E_DONE;
                        end
                    end
                end
            end
            EECMD_E_WAIT: begin
                // a missing part never signals ready, so only the counter ends the wait
                nxt_to = to_ff + 32'h1;
                if (tick) begin
                    nxt_cs = 1'b1;
                end
                if (cs_ff && miso_s_ff) begin
                    nxt_st = EECMD_E_DONE;
                end else if (to_ff >= 32'(TIMEOUT_CYC - 1)) begin
                    nxt_st = EECMD_E_DONE;
                    nxt_tmo = 1'b1;
                end
            end
            EECMD_E_DONE: begin
                nxt_st = EECMD_E_IDLE;
                nxt_cs = 1'b0;
                nxt_sck = 1'b0;
            end
            default: nxt_st = EECMD_E_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= EECMD_E_IDLE;
            sh_ff <= 19'h0;
            cnt_ff <= 5'h0;
            rd_ff <= 8'h0;
            div_ff <= 8'h0;
            to_ff <= 32'h0;
            ph_ff <= 1'b0;
            cs_ff <= 1'b0;
            sck_ff <= 1'b0;
            tmo_ff <= 1'b0;
            wr_ff <= 1'b0;
            miso_m_ff <= 1'b0;
            miso_s_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            rd_ff <= nxt_rd;
            div_ff <= nxt_div;
            to_ff <= nxt_to;
            ph_ff <= nxt_ph;
            cs_ff <= nxt_cs;
            sck_ff <= nxt_sck;
            tmo_ff <= nxt_tmo;
            wr_ff <= nxt_wr;
            miso_m_ff <= ee_miso;
            miso_s_ff <= miso_m_ff;
        end
    end
endmodule

// ### rtl/eecmd_if.sv
// request and answer between the command unit and its serial engine
// assumes both ends run on mclk
`timescale 1ns/10ps
interface eecmd_if;
    logic start;
    logic is_write;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
    logic tmo;

    modport ctl (output start, is_write, addr, wdata, input rdata, done, tmo);
    modport eng (input start, is_write, addr, wdata, output rdata, done, tmo);
endinterface

// ### rtl/eecmd_pkg.sv
// types shared by the eeprom command unit
// assumes nothing beyond the cfg header
package eecmd_pkg;
    typedef enum logic [1:0] {
        EECMD_LOAD = 2'h0,
        EECMD_IDLE = 2'h1,
        EECMD_RUN = 2'h3
    } eecmd_ctl_type;

    typedef enum logic [2:0] {
        EECMD_E_IDLE = 3'h0,
        EECMD_E_SEND = 3'h1,
        EECMD_E_RECV = 3'h3,
        EECMD_E_WAIT = 3'h2,
        EECMD_E_DONE = 3'h6
    } eecmd_eng_type;
endpackage

// ### rtl/eecmd_top.sv
// eeprom command register, busy handshake, reset-time address load and interrupts
// assumes a single-cycle register port master and an external serial eeprom
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`include "eecmd_cfg.svh"

// Overview of operation
// - writing one to command bit 31 starts the selected operation at the given address
// - busy stays set during the operation and clears by itself when finished
// - after a read, the fetched byte sits in the data register once busy clears
// - a write to a missing eeprom keeps busy until the timeout, then clears it
// - busy reads as set right after reset because the load starts at once
// - busy clears once the reset-time address load has read all six bytes
module eecmd_top
    import eecmd_pkg::*;
#(
    parameter int TIMEOUT_CYC = `EECMD_TIMEOUT_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    output logic [47:0] mac_addr,
    output logic mac_valid,
    output logic ee_cs,
    output logic ee_sck,
    output logic ee_mosi,
    input wire logic ee_miso
);
    initial begin
        if (TIMEOUT_CYC < 2) $error("timeout too short");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    eecmd_if eif ();

    eecmd_ctl_type st_ff, nxt_st;
    logic [2:0] op_ff, nxt_op;
    logic [7:0] addr_ff, nxt_addr;
    logic [7:0] data_ff, nxt_data;
    logic tmo_ff, nxt_tmo;
    logic start_ff, nxt_start;
    logic [2:0] ld_cnt_ff, nxt_ld_cnt;
    logic [47:0] mac_ff, nxt_mac;
    logic mac_ok_ff, nxt_mac_ok;
    logic [1:0] sts_ff, nxt_sts;
    logic [1:0] ien_ff, nxt_ien;
    logic [31:0] rdata_ff, nxt_rdata;
    logic busy;
    logic wr_cmd;
    logic [31:0] cmd_view;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign busy = (st_ff != EECMD_IDLE);
    assign wr_cmd = reg_wr && hit(reg_addr, `EECMD_OFS_CMD);

    // fields of the command word
    always_comb begin
        cmd_view = 32'h0;
        cmd_view[`EECMD_BUSY_BIT] = busy;
        cmd_view[`EECMD_OP_LSB +: 3] = op_ff;
        cmd_view[`EECMD_TMO_BIT] = tmo_ff;
        cmd_view[7:0] = addr_ff;
    end

    assign eif.start = start_ff;
    assign eif.is_write = (op_ff == `EECMD_OP_WRITE) && (st_ff == EECMD_RUN);
    // the load has no command word, so the byte counter supplies its address
    assign eif.addr = (st_ff == EECMD_LOAD) ? {5'h0, ld_cnt_ff} : addr_ff;
    assign eif.wdata = data_ff;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_op = op_ff;
        nxt_addr = addr_ff;
        nxt_data = data_ff;
        nxt_tmo = tmo_ff;
        nxt_start = 1'b0;
        nxt_ld_cnt = ld_cnt_ff;
        nxt_mac = mac_ff;
        nxt_mac_ok = mac_ok_ff;
        nxt_sts = sts_ff;
        nxt_ien = ien_ff;
        nxt_rdata = 32'h0;
        unique case (st_ff)
            EECMD_LOAD: begin
                // reset-time fetch of the station address, one byte per read
                if (eif.done) begin
                    nxt_mac[8 * ld_cnt_ff +: 8] = eif.rdata;
                    if (ld_cnt_ff == 3'(`EECMD_MAC_BYTES - 1)) begin
                        nxt_st = EECMD_IDLE;
                        nxt_mac_ok = 1'b1;
                    end else begin
                        nxt_ld_cnt = ld_cnt_ff + 3'h1;
                        nxt_start = 1'b1;
                    end
                end
            end
            EECMD_IDLE: begin
                // command and data writes while busy are dropped; software is expected to wait
                if (wr_cmd) begin
                    nxt_op = reg_wdata[`EECMD_OP_LSB +: 3];
                    nxt_addr = reg_wdata[7:0];
                    if (reg_wdata[`EECMD_BUSY_BIT]) begin
                        nxt_st = EECMD_RUN;
                        nxt_start = 1'b1;
                        nxt_tmo = 1'b0;
                    end
                end
                if (reg_wr && hit(reg_addr, `EECMD_OFS_DATA)) begin
                    nxt_data = reg_wdata[7:0];
                end
            end
            EECMD_RUN: begin
                if (eif.done) begin
                    nxt_st = EECMD_IDLE;
                    nxt_tmo = eif.tmo;
                    if (op_ff != `EECMD_OP_WRITE) begin
                        nxt_data = eif.rdata;
                    end
                end
            end
            default: nxt_st = EECMD_IDLE;
        endcase
        if (reg_wr && hit(reg_addr, `EECMD_OFS_ICLR)) begin
            nxt_sts = sts_ff & ~reg_wdata[1:0];
        end
        if (reg_wr && hit(reg_addr, `EECMD_OFS_IEN)) begin
            nxt_ien = reg_wdata[1:0];
        end
        // set after clear so an event in the clearing cycle is kept
        if (eif.done && st_ff == EECMD_RUN) begin
            nxt_sts[`EECMD_IRQ_DONE] = 1'b1;
            nxt_sts[`EECMD_IRQ_TMO] = sts_ff[`EECMD_IRQ_TMO] | eif.tmo;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `EECMD_OFS_CMD: nxt_rdata = cmd_view;
                `EECMD_OFS_DATA: nxt_rdata = {24'h0, data_ff};
                `EECMD_OFS_ISTS: nxt_rdata = {30'h0, sts_ff};
                `EECMD_OFS_IEN: nxt_rdata = {30'h0, ien_ff};
                default: nxt_rdata = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= EECMD_LOAD;
            op_ff <= `EECMD_OP_READ;
            addr_ff <= 8'h00;
            data_ff <= 8'h00;
            tmo_ff <= 1'b0;
            start_ff <= 1'b1;
            ld_cnt_ff <= 3'h0;
            mac_ff <= 48'h0;
            mac_ok_ff <= 1'b0;
            sts_ff <= 2'h0;
            ien_ff <= 2'h0;
            rdata_ff <= 32'h0;
        end else begin
            st_ff <= nxt_st;
            op_ff <= nxt_op;
            addr_ff <= nxt_addr;
            data_ff <= nxt_data;
            tmo_ff <= nxt_tmo;
            start_ff <= nxt_start;
            ld_cnt_ff <= nxt_ld_cnt;
            mac_ff <= nxt_mac;
            mac_ok_ff <= nxt_mac_ok;
            sts_ff <= nxt_sts;
            ien_ff <= nxt_ien;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign irq = |(sts_ff & ien_ff);
    assign mac_addr = mac_ff;
    assign mac_valid = mac_ok_ff;

    // the load reuses the normal read path; addresses come from the byte counter
    eecmd_engine #(
        .TIMEOUT_CYC(TIMEOUT_CYC)
    ) u_engine (
        .mclk(mclk),
        .resetn(resetn),
        .eng(eif.eng),
        .ee_cs(ee_cs),
        .ee_sck(ee_sck),
        .ee_mosi(ee_mosi),
        .ee_miso(ee_miso)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic seen_ff;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            seen_ff <= 1'b0;
        end else begin
            seen_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence s_go;
        wr_cmd && reg_wdata[`EECMD_BUSY_BIT] && !busy;
    endsequence

    sequence s_run_end;
        st_ff == EECMD_RUN && eif.done;
    endsequence

    sequence s_read_end;
        st_ff == EECMD_RUN && eif.done && op_ff != `EECMD_OP_WRITE;
    endsequence

    sequence s_tmo_end;
        st_ff == EECMD_RUN && eif.done && eif.tmo;
    endsequence

    // the load walks the addresses upward, one byte per finished read
    sequence s_load_step;
        st_ff == EECMD_LOAD && eif.done && ld_cnt_ff != 3'(`EECMD_MAC_BYTES - 1);
    endsequence

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    chk_go_busy: assert property (s_go |=> busy && start_ff)
        else $error("command write did not start an operation");
    chk_go_fields: assert property (s_go |=> eif.addr == $past(reg_wdata[7:0]))
        else $error("address field not taken from command write");
    chk_go_pin: assert property (s_go |=> ##1 ee_cs)
        else $error("eeprom not selected after command");
    chk_tmo_flag_clr: assert property (s_go |=> !tmo_ff)
        else $error("stale timeout flag at command start");
    chk_busy_hold: assert property (st_ff == EECMD_RUN && !eif.done |=> busy)
        else $error("busy dropped before operation end");
    chk_busy_clear: assert property (s_run_end |=> !busy ##1 !busy)
        else $error("busy not cleared after operation end");

    // software sees busy through the command word, one cycle later
    chk_busy_read: assert property (reg_rd && reg_addr == `EECMD_OFS_CMD
        |=> reg_rdata[`EECMD_BUSY_BIT] == $past(busy))
        else $error("busy bit not shown on command read");
    chk_read_data: assert property (s_read_end |=> data_ff == $past(eif.rdata))
        else $error("read byte not in data register");
    chk_write_keep: assert property (s_run_end ##0 (op_ff == `EECMD_OP_WRITE)
        |=> $stable(data_ff))
        else $error("write operation changed the data register");

    // only the ready wait of a write can run into the timeout
    chk_tmo_clear: assert property (s_tmo_end
        |=> !busy && tmo_ff && sts_ff[`EECMD_IRQ_TMO])
        else $error("timeout did not end write");
    chk_tmo_write: assert property (s_tmo_end |-> op_ff == `EECMD_OP_WRITE)
        else $error("timeout ended a non-write operation");

    chk_reset_busy: assert property (!seen_ff |-> busy && st_ff == EECMD_LOAD)
        else $error("busy not set after reset");
    chk_load_start: assert property (!seen_ff |-> start_ff)
        else $error("address load not started at reset release");
    chk_load_first: assert property (!seen_ff |-> eif.addr == 8'h00)
        else $error("address load not started at byte zero");
    chk_load_idle: assert property (st_ff == EECMD_LOAD |-> busy && !mac_valid)
        else $error("address valid or idle during load");
    chk_load_next: assert property (s_load_step
        |=> start_ff && busy && eif.addr == $past(eif.addr) + 8'h01)
        else $error("address load did not move to the next byte");
    chk_load_end: assert property (st_ff == EECMD_LOAD && eif.done
        && ld_cnt_ff == 3'(`EECMD_MAC_BYTES - 1) |=> !busy && mac_valid)
        else $error("busy not cleared after address load");
    chk_mac_keep: assert property (mac_valid |=> mac_valid && $stable(mac_addr))
        else $error("loaded address changed");

    chk_ignore_busy: assert property (wr_cmd && busy && st_ff == EECMD_RUN
        |=> $stable(addr_ff))
        else $error("command changed while busy");
    chk_op_keep: assert property (busy |=> $stable(op_ff) && $stable(addr_ff))
        else $error("command fields changed while busy");
endmodule

// ### verif/eecmd_eeprom_model.sv
// behavioural serial eeprom on the far side of the command unit's pins
// assumes frames of start bit, two op bits (read 01, write 10), eight address bits, msb first
`timescale 1ns/10ps
module eecmd_eeprom_model #(
    parameter int WR_DELAY = 40
) (
    input wire logic mclk,
    input wire logic present,
    input wire logic ee_cs,
    input wire logic ee_sck,
    input wire logic ee_mosi,
    output logic ee_miso
);
    logic [7:0] mem [0:255];
    logic [10:0] hdr;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic drv;
    logic tog;
    logic armed;
    logic waiting;
    int nbit;
    int busy_cnt;

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
        hdr = 11'h0;
        nbit = 0;
        armed = 1'b0;
        waiting = 1'b0;
        tog = 1'b0;
        drv = 1'b0;
        busy_cnt = 0;
    end

    // ------------------------------------------------------------
    // serial frame
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        tog <= ~tog;
        if (!waiting) begin
            busy_cnt <= 0;
        end else if (busy_cnt < WR_DELAY) begin
            busy_cnt <= busy_cnt + 1;
        end
    end

    always @(posedge ee_sck) begin
        if (ee_cs && !waiting) begin
            if (nbit < 11) begin
                hdr = {hdr[9:0], ee_mosi};
            end else if (nbit < 19) begin
                wbyte = {wbyte[6:0], ee_mosi};
            end
            nbit = nbit + 1;
            if (nbit == 11) begin
                rbyte = mem[hdr[7:0]];
            end
        end
    end

    always @(negedge ee_sck) begin
        if (ee_cs && nbit >= 11 && hdr[9:8] == 2'b01) begin
            drv = rbyte[7];
            rbyte = {rbyte[6:0], 1'b0};
        end
    end

    // a write lands at the first chip-select drop, then the ready wait follows
    always @(negedge ee_cs) begin
        if (present && hdr[9:8] == 2'b10 && nbit == 19) begin
            mem[hdr[7:0]] = wbyte;
            armed = 1'b1;
        end
        waiting = 1'b0;
        nbit = 0;
    end

    always @(posedge ee_cs) begin
        waiting = armed;
        armed = 1'b0;
        nbit = 0;
    end

    // a selected part that is not driving toggles so a stale level is never taken as data
    // the line is pulled down while deselected or absent, so no false ready appears
    assign ee_miso = !present ? 1'b0 : !ee_cs ? 1'b0 :
        waiting ? (busy_cnt == WR_DELAY) :
        (nbit >= 11 && hdr[9:8] == 2'b01) ? drv : tog;
endmodule

// ### verif/testbench.sv
// self-checking bench for the eeprom command unit: registers, busy handshake, interrupts
// assumes the behavioural eeprom model on the serial pins and a shortened write timeout
`timescale 1ns/10ps
`include "eecmd_cfg.svh"
module testbench
    import eecmd_pkg::*;
;
    localparam int TMO = 200;
    localparam int WDLY = 40;
    // extra busy time of an absent part: timeout less the ready gap and the ready delay
    localparam int WIN = TMO - WDLY - `EECMD_SCK_DIV;
    logic mclk, resetn, reg_wr, reg_rd, irq, mac_valid, present;
    logic ee_cs, ee_sck, ee_mosi, ee_miso;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [47:0] mac_addr;
    int err_count, total_checks, cyc, wr_took;

    eecmd_top #(.TIMEOUT_CYC(TMO)) uut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .mac_addr(mac_addr), .mac_valid(mac_valid), .ee_cs(ee_cs),
        .ee_sck(ee_sck), .ee_mosi(ee_mosi), .ee_miso(ee_miso));
    eecmd_eeprom_model #(.WR_DELAY(WDLY)) ee (.mclk(mclk), .present(present), .ee_cs(ee_cs),
        .ee_sck(ee_sck), .ee_mosi(ee_mosi), .ee_miso(ee_miso));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] pat(input logic [7:0] a);
        return a ^ 8'h5a;
    endfunction

    task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_sim();
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // every access costs two cycles so no strobe is assigned twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rdr(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
        @(posedge mclk);
    endtask

    // software polls busy and touches nothing else meanwhile
    task automatic wait_idle(output int took);
        int t0;
        t0 = cyc;
        for (int i = 0; i < 12000; i++) begin
            rdr(`EECMD_OFS_CMD);
            if (rd[`EECMD_BUSY_BIT] === 1'b0) begin
                took = cyc - t0;
                return;
            end
        end
        err_count++;
        $display("[ERR] busy clear expected 0 seen 1");
        end_sim();
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        int took;
        rdr(`EECMD_OFS_CMD);
        chk("busy after reset", 48'h1, rd[`EECMD_BUSY_BIT]);
        wait_idle(took);
        chk("mac valid", 48'h1, mac_valid);
        for (int n = 0; n < `EECMD_MAC_BYTES; n++) begin
            chk("mac byte", pat(8'(n)), mac_addr[8*n +: 8]);
        end
        rdr(`EECMD_OFS_ISTS);
        chk("status after load", 48'h0, rd);
    endtask

    task automatic t_read(input logic [7:0] a, input logic [7:0] exp);
        int took;
        wr(`EECMD_OFS_CMD, {1'b1, `EECMD_OP_READ, 20'h0, a});
        rdr(`EECMD_OFS_CMD);
        chk("busy in read", 48'h1, rd[`EECMD_BUSY_BIT]);
        chk("op and addr", {`EECMD_OP_READ, a}, {rd[30:28], rd[7:0]});
        wait_idle(took);
        chk("read frame ran", 48'h1, took > 1000);
        chk("read no timeout", 48'h0, rd[`EECMD_TMO_BIT]);
        rdr(`EECMD_OFS_DATA);
        chk("read byte", exp, rd[7:0]);
    endtask

    task automatic t_write(input logic [7:0] a, input logic [7:0] d, input logic here);
        int took;
        present <= here;
        wr(`EECMD_OFS_DATA, {24'h0, d});
        wr(`EECMD_OFS_CMD, {1'b1, `EECMD_OP_WRITE, 20'h0, a});
        wait_idle(took);
        chk("write timeout flag", !here, rd[`EECMD_TMO_BIT]);
        if (here) begin
            wr_took = took;
        end else begin
            // absent part is held for the timeout instead of the ready wait
            chk("timeout low", 48'h1, took - wr_took >= WIN - 8);
            chk("timeout high", 48'h1, took - wr_took <= WIN + 8);
        end
        present <= 1'b1;
    endtask

    task automatic t_irq(input logic [1:0] ev);
        wr(`EECMD_OFS_IEN, 32'h0);
        rdr(`EECMD_OFS_ISTS);
        chk("status event", ev, rd[1:0] & ev);
        chk("irq masked", 48'h0, irq);
        wr(`EECMD_OFS_IEN, {30'h0, ev});
        chk("irq enabled", 48'h1, irq);
        wr(`EECMD_OFS_ICLR, 32'h3);
        rdr(`EECMD_OFS_ISTS);
        chk("status cleared", 48'h0, rd);
        chk("irq cleared", 48'h0, irq);
    endtask

    task automatic t_map();
        wr(8'h40, 32'hffffffff);
        rdr(8'h40);
        chk("unmapped read", 48'h0, rd);
        rdr(`EECMD_OFS_ICLR);
        chk("clear reg read", 48'h0, rd);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        present = 1'b1;
        err_count = 0;
        total_checks = 0;
        cyc = 0;
        wr_took = 0;
        repeat (12) @(posedge mclk);
        chk("irq in reset", 48'h0, irq);
        chk("rdata in reset", 48'h0, reg_rdata);
        resetn <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_read(8'h25, pat(8'h25));
        t_irq(2'b01);
        t_write(8'h40, 8'hc3, 1'b1);
        t_read(8'h40, 8'hc3);
        t_write(8'h41, 8'h3c, 1'b0);
        t_irq(2'b10);
        t_read(8'h41, pat(8'h41));
        t_map();
        end_sim();
    end
endmodule
